// ---- include/clh_consts.svh ----
// Constants of the character display host interface: offsets, fields, resets, timing.
// Assumes it is included by its bare name from the design modules and the bench.
`ifndef CLH_CONSTS_SVH
`define CLH_CONSTS_SVH

// ****************************************************************
// Serial port
// ****************************************************************
`define CLH_SLAVE_ADDR     7'h3e
`define CLH_CTRL_CO_BIT    7
`define CLH_CTRL_RS_BIT    6
`define CLH_BITS_PER_BYTE  4'h8
`define CLH_ACK_SLOT       4'h9

// ****************************************************************
// Instruction fields
// ****************************************************************
`define CLH_OP_SETADDR_BIT 7
`define CLH_OP_FUNC_CODE   3'h1
`define CLH_OP_ENTRY_CODE  6'h01
`define CLH_FUNC_DL_BIT    4
`define CLH_ENTRY_ID_BIT   1

// ****************************************************************
// Display RAM and reset values
// ****************************************************************
`define CLH_RAM_DEPTH      80
`define CLH_RAM_LAST       7'h4f
`define CLH_RST_WIDTH8     1'b1
`define CLH_RST_INCR       1'b1
`define CLH_RST_PTR        7'h00
`define CLH_RST_SYNC       13'h1800

// ****************************************************************
// Timing
// ****************************************************************
`define CLH_CLK_MHZ        20
`define CLH_INSTR_TIME_NS  27000
`define CLH_BUSY_CYCLES    ((`CLH_INSTR_TIME_NS * `CLH_CLK_MHZ + 999) / 1000)

`endif

// ---- include/clh_pkg.sv ----
// Types shared by the host interface modules.
// Assumes clh_consts.svh is on the include path.
package clh_pkg;
  typedef logic [7:0] clh_byte_t;
  typedef logic [6:0] clh_addr_t;
  typedef logic [9:0] clh_busy_t;
  typedef enum logic [2:0] {
    clh_i2c_idle,
    clh_i2c_addr,
    clh_i2c_ctrl,
    clh_i2c_data,
    clh_i2c_skip
  } clh_i2c_state_e;
endpackage

// ---- include/clh_ram_if.sv ----
// Port between the interface logic and the display character memory.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface clh_ram_if;
  logic                we;
  clh_pkg::clh_addr_t  addr;
  clh_pkg::clh_byte_t  wdata;
  clh_pkg::clh_byte_t  rdata;
  modport host (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ---- rtl/clh_ram.sv ----
// Display character memory, 80 words of 8 bits, read data registered.
// Assumes addresses above the last word are dropped on write and read as zero.
`timescale 1ns/10ps
`include "clh_consts.svh"
module clh_ram (
  // Clock
  input wire logic mclk,
  // Memory port
  clh_ram_if.mem   port
);
  import clh_pkg::*;

  clh_byte_t mem_q [`CLH_RAM_DEPTH];
  wire       in_range = (port.addr <= `CLH_RAM_LAST);

  always_ff @(posedge mclk) begin
    if (port.we && in_range) begin
      mem_q[port.addr] <= port.wdata;
    end
    port.rdata <= in_range ? mem_q[port.addr] : 8'h00;
  end
endmodule // clh_ram

// ---- rtl/clh_top.sv ----
// Host interface of a character display controller: parallel bus and write-only two-wire port.
// Assumes all pins arrive asynchronously to mclk and that the two-wire clock is far slower than mclk.
//
// Overview of operation
// - Parallel bus 4 or 8 bits by instruction.
// - Separate instruction and data latches; only the instruction latch is write-only.
// - Data read prefetches the next RAM location.
// - Data write moves latch into selected RAM.
// - Select and direction decode four parallel operations.
// - Serial port writes only, drives acknowledge only.
// - Fixed serial address 0111110, write direction.
// - Start and stop while clock is high.
// - Acknowledge each byte of an addressed write on the ninth pulse.
// - Foreign address makes whole transfer ignored.
// - Command word is control then data byte.
// - Cleared continuation makes all further bytes data.
// - Select one stores byte in RAM, steps.
// - Select zero decodes the byte as instruction.
// - Serial acknowledge ignores the busy state.
// - Busy blocks further instructions while operating.
// - Pointer loaded by instruction, steps by one.
// - Display RAM holds 80 eight-bit codes.
`timescale 1ns/10ps
`include "clh_consts.svh"
module clh_top (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Parallel bus
  input  wire logic              reg_select,
  input  wire logic              read_not_write,
  input  wire logic              bus_enable,
  input  wire clh_pkg::clh_byte_t bus_in,
  output logic [7:0]             bus_out,
  output logic                   bus_oe,
  // Two-wire port
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // Status
  output logic                   busy_indicator,
  output clh_pkg::clh_addr_t     ram_address_pointer,
  output logic                   bus_width_select
);
  import clh_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int SYNC_W = 13;
  // The two-wire lines reset to their idle high level, so no false edge follows reset.
  localparam logic [SYNC_W-1:0] SYNC_IDLE = `CLH_RST_SYNC;
  wire  [SYNC_W-1:0] pin_raw = {scl_in, sda_in, bus_enable, reg_select, read_not_write, bus_in};
  logic [SYNC_W-1:0] pin_s;
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      logic stage1;
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          stage1    <= SYNC_IDLE[gi];
          pin_s[gi] <= SYNC_IDLE[gi];
        end else begin
          stage1    <= pin_raw[gi];
          pin_s[gi] <= stage1;
        end
      end
    end
  endgenerate

  wire       scl_s = pin_s[12];
  wire       sda_s = pin_s[11];
  wire       en_s  = pin_s[10];
  wire       rs_s  = pin_s[9];
  wire       rw_s  = pin_s[8];
  clh_byte_t db_s;
  assign db_s = pin_s[7:0];

  // ****************************************************************
  // Shared state
  // ****************************************************************
  clh_byte_t instruction_code_latch;
  clh_byte_t ram_data_latch;
  logic      incr;
  logic      wr_pend;
  logic [1:0] fetch;
  clh_busy_t busy_cnt;
  clh_ram_if ram ();

  clh_ram u_ram (
    .mclk (mclk),
    .port (ram.mem)
  );

  // ****************************************************************
  // Parallel bus
  // ****************************************************************
  logic en_p;
  logic nib_phase;
  logic [3:0] nib_hi;
  wire  en_fall   = en_p & ~en_s;
  wire  width4    = ~bus_width_select;
  wire  nib_last  = ~width4 | nib_phase;
  wire  par_done  = en_fall & nib_last;
  wire  par_wr    = par_done & ~rw_s;
  wire  par_rd    = par_done & rw_s & rs_s;
  clh_byte_t par_byte;
  clh_byte_t rd_byte;
  clh_byte_t next_bus_out;
  assign par_byte = width4 ? {nib_hi, db_s[7:4]} : db_s;
  assign rd_byte  = rs_s ? ram_data_latch : {busy_indicator, ram_address_pointer};
  assign next_bus_out = !width4 ? rd_byte : (nib_phase ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});
  assign bus_oe   = en_s & rw_s;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      en_p      <= 1'b0;
      nib_phase <= 1'b0;
      nib_hi    <= 4'h0;
      bus_out   <= 8'h00;
    end else begin
      en_p    <= en_s;
      bus_out <= next_bus_out;
      if (en_fall && width4) begin
        nib_phase <= ~nib_phase;
        nib_hi    <= db_s[7:4];
      end else if (!width4) begin
        nib_phase <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Two-wire slave
  // ****************************************************************
  clh_i2c_state_e state;
  logic      scl_p;
  logic      sda_p;
  logic [3:0] bit_cnt;
  clh_byte_t shreg;
  logic      ctrl_rs;
  logic      data_only;
  logic      i2c_req;
  logic      i2c_rs;
  clh_byte_t i2c_byte;
  wire  scl_rise  = scl_s & ~scl_p;
  wire  scl_fall  = ~scl_s & scl_p;
  wire  start_cnd = scl_s & scl_p & sda_p & ~sda_s;
  wire  stop_cnd  = scl_s & scl_p & ~sda_p & sda_s;
  wire  active    = (state != clh_i2c_idle) && (state != clh_i2c_skip);
  wire  byte_done = active & scl_fall & (bit_cnt == `CLH_BITS_PER_BYTE);
  wire  addr_ok   = (shreg[7:1] == `CLH_SLAVE_ADDR) && !shreg[0];
  assign sda_out  = 1'b0;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state     <= clh_i2c_idle;
      scl_p     <= 1'b1;
      sda_p     <= 1'b1;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      ctrl_rs   <= 1'b0;
      data_only <= 1'b0;
      sda_oe    <= 1'b0;
      i2c_req   <= 1'b0;
      i2c_rs    <= 1'b0;
      i2c_byte  <= 8'h00;
    end else begin
      scl_p   <= scl_s;
      sda_p   <= sda_s;
      i2c_req <= 1'b0;
      if (start_cnd) begin
        state     <= clh_i2c_addr;
        bit_cnt   <= 4'h0;
        data_only <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (stop_cnd) begin
        state  <= clh_i2c_idle;
        sda_oe <= 1'b0;
      end else if (active) begin
        if (scl_rise && bit_cnt < `CLH_BITS_PER_BYTE) begin
          shreg   <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall && bit_cnt == `CLH_ACK_SLOT) begin
          sda_oe  <= 1'b0;
          bit_cnt <= 4'h0;
        end else if (byte_done) begin
          bit_cnt <= `CLH_ACK_SLOT;
          case (state)
            clh_i2c_addr: begin
              sda_oe <= addr_ok;
              state  <= addr_ok ? clh_i2c_ctrl : clh_i2c_skip;
            end
            clh_i2c_ctrl: begin
              sda_oe    <= 1'b1;
              ctrl_rs   <= shreg[`CLH_CTRL_RS_BIT];
              data_only <= ~shreg[`CLH_CTRL_CO_BIT];
              state     <= clh_i2c_data;
            end
            clh_i2c_data: begin
              sda_oe   <= 1'b1;
              i2c_req  <= 1'b1;
              i2c_rs   <= ctrl_rs;
              i2c_byte <= shreg;
              state    <= data_only ? clh_i2c_data : clh_i2c_ctrl;
            end
            default: begin
              state <= clh_i2c_skip;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Instruction and data path
  // ****************************************************************
  // The parallel port wins a same-cycle clash; a system uses only one port at a time.
  wire       req_v    = par_wr | i2c_req;
  wire       req_rs   = par_wr ? rs_s : i2c_rs;
  clh_byte_t req_byte;
  assign req_byte = par_wr ? par_byte : i2c_byte;
  wire       instr_ok = req_v & ~req_rs & ~busy_indicator;
  wire       data_wr  = req_v & req_rs;
  wire       op_addr  = instr_ok & req_byte[`CLH_OP_SETADDR_BIT];
  wire       op_func  = instr_ok & (req_byte[7:5] == `CLH_OP_FUNC_CODE);
  wire       op_entry = instr_ok & (req_byte[7:2] == `CLH_OP_ENTRY_CODE);
  wire       step_now = wr_pend | par_rd;
  clh_addr_t ptr_step;
  assign ptr_step = incr ? ((ram_address_pointer == `CLH_RAM_LAST) ? 7'h00 : ram_address_pointer + 7'h01)
                         : ((ram_address_pointer == 7'h00) ? `CLH_RAM_LAST : ram_address_pointer - 7'h01);
  assign busy_indicator = (busy_cnt != 10'h000);
  assign ram.we    = wr_pend;
  assign ram.addr  = ram_address_pointer;
  assign ram.wdata = ram_data_latch;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      instruction_code_latch <= 8'h00;
      ram_data_latch         <= 8'h00;
      ram_address_pointer    <= `CLH_RST_PTR;
      bus_width_select       <= `CLH_RST_WIDTH8;
      incr                   <= `CLH_RST_INCR;
      wr_pend                <= 1'b0;
      fetch                  <= 2'b00;
      busy_cnt               <= 10'h000;
    end else begin
      wr_pend <= data_wr;
      fetch   <= {fetch[0], op_addr | par_rd};
      if (instr_ok) begin
        instruction_code_latch <= req_byte;
        busy_cnt               <= 10'(`CLH_BUSY_CYCLES);
      end else if (busy_indicator) begin
        busy_cnt <= busy_cnt - 10'h001;
      end
      if (op_func) begin
        bus_width_select <= req_byte[`CLH_FUNC_DL_BIT];
      end
      if (op_entry) begin
        incr <= req_byte[`CLH_ENTRY_ID_BIT];
      end
      if (op_addr) begin
        ram_address_pointer <= req_byte[6:0];
      end else if (step_now) begin
        ram_address_pointer <= ptr_step;
      end
      if (data_wr) begin
        ram_data_latch <= req_byte;
      end else if (fetch[1]) begin
        ram_data_latch <= ram.rdata;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_data_write;
    data_wr ##1 wr_pend;
  endsequence
  sequence s_host_read;
    par_rd && !op_addr ##2 fetch[1];
  endsequence

  property p_instr_blocked;
    req_v && !req_rs && busy_indicator |=> $stable(instruction_code_latch) && $stable(bus_width_select);
  endproperty
  a_instr_blocked: assert property (p_instr_blocked) else $error("instruction taken while busy");

  property p_busy_hold;
    instr_ok |=> busy_indicator [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_write_to_ram;
    s_data_write |-> ram.we && ram.wdata == $past(req_byte) && ram.addr == $past(ram_address_pointer);
  endproperty
  a_write_to_ram: assert property (p_write_to_ram) else $error("data write not sent to memory");

  property p_step_after_write;
    wr_pend && !op_addr && incr && ram_address_pointer != `CLH_RAM_LAST
      |=> ram_address_pointer == $past(ram_address_pointer) + 7'h01;
  endproperty
  a_step_after_write: assert property (p_step_after_write) else $error("pointer did not step");

  property p_prefetch;
    s_host_read |=> ram_data_latch === $past(ram.rdata) || $past(data_wr);
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("next location not fetched");

  property p_status_read;
    en_s && rw_s && !rs_s && !width4 && $stable(busy_indicator) && $stable(ram_address_pointer)
      |=> bus_out == {$past(busy_indicator), $past(ram_address_pointer)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_no_foreign_ack;
    byte_done && state == clh_i2c_addr && !addr_ok |=> !sda_oe && state == clh_i2c_skip;
  endproperty
  a_no_foreign_ack: assert property (p_no_foreign_ack) else $error("foreign or read address acknowledged");

  property p_ack_own;
    byte_done && state == clh_i2c_addr && addr_ok |=> sda_oe && state == clh_i2c_ctrl;
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("own address not acknowledged");

  property p_ack_only_in_slot;
    sda_oe |-> bit_cnt == `CLH_ACK_SLOT && active;
  endproperty
  a_ack_only_in_slot: assert property (p_ack_only_in_slot) else $error("data line driven outside acknowledge");

  property p_skip_quiet;
    state == clh_i2c_skip |-> !i2c_req && !sda_oe;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("ignored transfer had effect");

  property p_data_only_sticks;
    byte_done && state == clh_i2c_data && data_only |=> state == clh_i2c_data && i2c_req && i2c_rs == ctrl_rs;
  endproperty
  a_data_only_sticks: assert property (p_data_only_sticks) else $error("data run left early");

  property p_ack_ignores_busy;
    byte_done && state == clh_i2c_data && busy_indicator |=> sda_oe;
  endproperty
  a_ack_ignores_busy: assert property (p_ack_ignores_busy) else $error("acknowledge held back by busy");
endmodule // clh_top

// ---- verif/clh_i2c_master.sv ----
// Two-wire bus master model standing in for the host processor on the serial port.
// Assumes a pull-up on the data line and a bench that calls its tasks in frame order.
`timescale 1ns/10ps
module clh_i2c_master (
  // Clock
  input  wire logic mclk,
  // Device side of the data line
  input  wire logic sda_out,
  input  wire logic sda_oe,
  // Wire levels
  output logic      scl,
  output logic      sda
);
  logic sda_drive;

  // The line is pulled up, so either party can only pull it low.
  assign sda = sda_drive & ~(sda_oe & ~sda_out);

  initial begin
    scl       = 1'b1;
    sda_drive = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Only called with both lines idle high.
  task automatic start_cond;
    sda_drive <= 1'b0;
    wait_clk(4);
    scl <= 1'b0;
    wait_clk(4);
  endtask

  task automatic put_byte(input clh_pkg::clh_byte_t b, output logic ack);
    logic a0;
    for (int i = 7; i >= 0; i--) begin
      sda_drive <= b[i];
      wait_clk(2);
      scl <= 1'b1;
      wait_clk(4);
      scl <= 1'b0;
      wait_clk(2);
    end
    sda_drive <= 1'b1;
    wait_clk(2);
    scl <= 1'b1;
    wait_clk(1);
    a0 = ~sda;
    wait_clk(2);
    ack = a0 & ~sda;
    wait_clk(1);
    scl <= 1'b0;
    wait_clk(2);
  endtask

  // Every frame ends with a stop, leaving the bus idle.
  task automatic stop_cond;
    sda_drive <= 1'b0;
    wait_clk(2);
    scl <= 1'b1;
    wait_clk(4);
    sda_drive <= 1'b1;
    wait_clk(4);
  endtask
endmodule // clh_i2c_master

// ---- verif/tb_top.sv ----
// Self-checking bench for the character display host interface.
// Assumes the design files, the package and the constants header are compiled first.
`timescale 1ns/10ps
`include "clh_consts.svh"
`define TB_CHECK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: %s", $time, msg); end end
module tb_top;
  import clh_pkg::*;
  logic               mclk;
  logic               reset;
  logic               reg_select;
  logic               read_not_write;
  logic               bus_enable;
  clh_byte_t          bus_in;
  logic [7:0]         bus_out;
  logic               bus_oe;
  logic               scl;
  logic               sda;
  logic               sda_out;
  logic               sda_oe;
  logic               busy_indicator;
  clh_addr_t          ram_address_pointer;
  logic               bus_width_select;
  int                 fail_count;
  int                 compares;
  int                 cycles;
  localparam clh_byte_t ADDR_WR = {`CLH_SLAVE_ADDR, 1'b0};

  clh_top clh_top_inst (.mclk(mclk), .reset(reset), .reg_select(reg_select),
    .read_not_write(read_not_write), .bus_enable(bus_enable), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .busy_indicator(busy_indicator), .ram_address_pointer(ram_address_pointer),
    .bus_width_select(bus_width_select));
  clh_i2c_master clh_i2c_master_inst (.mclk(mclk), .sda_out(sda_out), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  always #25 mclk = ~mclk;

  task automatic test_done;
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the few thousand cycles the sequence needs.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      test_done();
    end
  end

  // ****************************************************************
  // Parallel bus and serial frame tasks
  // ****************************************************************
  // Pins are held well beyond the two-flop synchroniser around the strobe's fall.
  task automatic acc(input logic rs, input logic rw, input clh_byte_t d, output clh_byte_t r);
    @(posedge mclk);
    reg_select     <= rs;
    read_not_write <= rw;
    bus_in         <= d;
    repeat (4) @(posedge mclk);
    bus_enable <= 1'b1;
    repeat (6) @(posedge mclk);
    r = bus_out;
    `TB_CHECK(bus_oe, rw, "bus drive enable")
    bus_enable <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic wr(input logic rs, input clh_byte_t d);
    clh_byte_t r;
    acc(rs, 1'b0, d, r);
  endtask

  task automatic rd(input logic rs, input clh_byte_t exp);
    clh_byte_t r;
    acc(rs, 1'b1, 8'h00, r);
    `TB_CHECK(r, exp, "read data")
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_indicator !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    `TB_CHECK(busy_indicator, 1'b0, "busy never cleared")
  endtask

  task automatic instr(input clh_byte_t d);
    wr(1'b0, d);
    wait_idle();
  endtask

  task automatic tx(input clh_byte_t b, input logic exp_ack);
    logic ack;
    clh_i2c_master_inst.put_byte(b, ack);
    `TB_CHECK(ack, exp_ack, "acknowledge")
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    mclk           = 1'b0;
    reset          = 1'b1;
    reg_select     = 1'b0;
    read_not_write = 1'b0;
    bus_enable     = 1'b0;
    bus_in         = 8'h00;
    fail_count     = 0;
    compares       = 0;
    cycles         = 0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    `TB_CHECK(bus_width_select, 1'b1, "width after reset")
    `TB_CHECK(ram_address_pointer, 7'h00, "pointer after reset")
    wr(1'b0, 8'h85);
    rd(1'b0, 8'h85);
    wait_idle();
    wr(1'b1, 8'h41);
    wr(1'b1, 8'h42);
    `TB_CHECK(ram_address_pointer, 7'h07, "pointer after writes")
    instr(8'h85);
    rd(1'b1, 8'h41);
    rd(1'b1, 8'h42);
    rd(1'b0, 8'h07);
    // The second instruction lands while the first still runs.
    wr(1'b0, 8'h90);
    wr(1'b0, 8'ha0);
    wait_idle();
    `TB_CHECK(ram_address_pointer, 7'h10, "instruction taken while busy")
    instr(8'h80);
    instr(8'h04);
    wr(1'b1, 8'h5a);
    `TB_CHECK(ram_address_pointer, 7'h4f, "decrement wraps below zero")
    instr(8'h06);
    instr(8'ha0);
    // Command word with continuation, then instructions; the second arrives while busy.
    clh_i2c_master_inst.start_cond();
    tx(ADDR_WR, 1'b1);
    tx(8'hc0, 1'b1);
    tx(8'h33, 1'b1);
    tx(8'h1f, 1'b1);
    tx(8'h88, 1'b1);
    tx(8'h90, 1'b1);
    clh_i2c_master_inst.stop_cond();
    wait_idle();
    `TB_CHECK(ram_address_pointer, 7'h08, "serial instruction")
    clh_i2c_master_inst.start_cond();
    tx(ADDR_WR, 1'b1);
    tx(8'h7f, 1'b1);
    tx(8'h61, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h63, 1'b1);
    clh_i2c_master_inst.stop_cond();
    `TB_CHECK(ram_address_pointer, 7'h0b, "serial data steps pointer")
    instr(8'h88);
    rd(1'b1, 8'h61);
    rd(1'b1, 8'h80);
    rd(1'b1, 8'h63);
    instr(8'ha0);
    rd(1'b1, 8'h33);
    clh_i2c_master_inst.start_cond();
    tx({`CLH_SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
    tx(8'h40, 1'b0);
    tx(8'h77, 1'b0);
    clh_i2c_master_inst.stop_cond();
    clh_i2c_master_inst.start_cond();
    tx({`CLH_SLAVE_ADDR, 1'b1}, 1'b0);
    tx(8'h40, 1'b0);
    clh_i2c_master_inst.stop_cond();
    `TB_CHECK(ram_address_pointer, 7'h21, "ignored frames")
    instr(8'h20);
    `TB_CHECK(bus_width_select, 1'b0, "four-bit mode")
    // Status in four-bit mode comes high nibble first, each half in bits 7 to 4.
    rd(1'b0, 8'h20);
    rd(1'b0, 8'h10);
    wr(1'b0, 8'h30);
    wr(1'b0, 8'h00);
    wait_idle();
    `TB_CHECK(bus_width_select, 1'b1, "nibble pair back to eight bits")
    test_done();
  end
endmodule // tb_top
